// [design/fmc_pkg.sv]
// constants and carrier types of the float multiply / compare-flag-probe unit
// assumes one core clock (mclk) and a classic wishbone master for software access
//
// Overview of operation
// - less-than probe, opcode 145, one cycle, writes exception vector of a<b
// - probe leaves status word alone; its vector uses the status-word flag layout
// - denormal compare operand counts as zero and sets input-flushed bit 0x20
// - quiet NaN compare operand gives vector 0x10, the bad-operand bit
// - probe writes its target only when guard lsb is one
// - multiply, opcode 28, three cycles, slots 2 or 3, writes single product
// - product is rounded by the status word rounding-mode bits
// - denormal multiply operand becomes zero and sets input-flushed status flag
// - denormal product becomes zero and sets output-flushed status flag
// - multiply exceptions set sticky status flags, cleared only by status writes
// - flag update coincides with target write; updates OR into existing flags
// - multiply with guard lsb zero changes neither target nor any flag
// - infinity times zero gives 0xFFFFFFFF and sets bad-operand flag
// - overflow returns infinity 0x7F800000, or max finite where the rounding mode points toward zero, and sets too-large and precision-loss
// - product in denormal range returns zero, sets output-flushed, too-small, precision-loss
// - vector bits: precision-loss 1, too-small 2, too-large 3, output-flushed 6
package fmc_pkg;

    // ----------
    // opcodes and issue
    // ----------
    localparam logic [7:0] OPC_PROBE_LT = 8'h91;   // 145
    localparam logic [7:0] OPC_FMUL = 8'h1C;       // 28
    localparam int CMP_LATENCY = 1;
    localparam int MUL_LATENCY = 3;
    localparam logic [1:0] MUL_SLOT_A = 2'h2;
    localparam logic [1:0] MUL_SLOT_B = 2'h3;
    localparam int DEST_W = 7;

    // ----------
    // exception vector layout
    // ----------
    localparam int FLAG_W = 7;
    localparam int BIT_PRECISION_LOSS = 1;
    localparam int BIT_TOO_SMALL = 2;
    localparam int BIT_TOO_LARGE = 3;
    localparam int BIT_BAD_OPERAND = 4;
    localparam int BIT_INPUT_FLUSHED = 5;
    localparam int BIT_OUTPUT_FLUSHED = 6;
    localparam logic [FLAG_W-1:0] FLAG_IMPL_MASK = 7'h7E;

    // ----------
    // float constants
    // ----------
    localparam logic [31:0] QNAN_PATTERN = 32'hFFFFFFFF;
    localparam logic [7:0] EXP_ALL_ONES = 8'hFF;
    localparam logic [9:0] EXP_BIAS = 10'h07F;
    localparam logic [9:0] EXP_LIMIT = 10'h0FF;
    localparam logic [9:0] DENORM_FLOOR = 10'h3E9;  // -23 in ten-bit two's complement
    localparam logic [30:0] MAX_FINITE_MAG = 31'h7F7FFFFF;
    localparam logic [30:0] INF_MAG = 31'h7F800000;

    // ----------
    // register map (byte addresses) and fields
    // ----------
    localparam logic [7:0] ADDR_STATUS_WORD = 8'h00;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;
    localparam int RMODE_LSB = 8;
    localparam logic [31:0] STATUS_WORD_RESET = 32'h00000000;
    localparam int IRQ_W = 3;
    localparam int IRQ_MUL_EXC = 0;
    localparam int IRQ_PROBE_EXC = 1;
    localparam int IRQ_REFUSED = 2;

    typedef enum logic [1:0] {
        RM_NEAREST = 2'b00,
        RM_TO_ZERO = 2'b01,
        RM_TO_POS = 2'b10,
        RM_TO_NEG = 2'b11
    } fmc_rmode_t;

    typedef struct packed {
        logic valid;
        logic guard;
        logic [7:0] opcode;
        logic [1:0] slot;
        logic [31:0] first_operand;
        logic [31:0] second_operand;
        logic [DEST_W-1:0] dest;
    } fmc_issue_t;

    typedef struct packed {
        logic valid;
        logic [DEST_W-1:0] dest;
        logic [31:0] data;
    } fmc_wb_t;

endpackage : fmc_pkg

// [design/fmc_cmp_probe.sv]
// less-than flag probe: exception vector of first < second, one-cycle latency
// assumes issue logic on mclk; never touches the status word
`timescale 1ns/1ps
`default_nettype none
module fmc_cmp_probe (
    input wire logic mclk,
    input wire logic rst,
    input wire fmc_pkg::fmc_issue_t issue,
    output fmc_pkg::fmc_wb_t result,
    output logic flagged
);
    import fmc_pkg::*;

    logic take;
    logic [FLAG_W-1:0] vec_next;

    function automatic logic is_denorm(input logic [31:0] v);
        return (v[30:23] == 8'h00) && (v[22:0] != 23'h000000);
    endfunction : is_denorm

    function automatic logic is_nan(input logic [31:0] v);
        return (v[30:23] == EXP_ALL_ONES) && (v[22:0] != 23'h000000);
    endfunction : is_nan

    // ----------
    // flag computation
    // ----------
    // less-than is a signalling compare: any NaN raises bad-operand
    always_comb begin
        vec_next = '0;
        vec_next[BIT_INPUT_FLUSHED] = is_denorm(issue.first_operand)
            | is_denorm(issue.second_operand);
        vec_next[BIT_BAD_OPERAND] = is_nan(issue.first_operand)
            | is_nan(issue.second_operand);
        vec_next = vec_next & FLAG_IMPL_MASK;
    end

    assign take = issue.valid && issue.guard && (issue.opcode == OPC_PROBE_LT);

    // ----------
    // result register
    // ----------
    always_ff @(posedge mclk) begin
        if (rst) begin
            result <= '0;
            flagged <= 1'b0;
        end else begin
            result.valid <= take;
            flagged <= take && (vec_next != '0);
            if (take) begin
                result.dest <= issue.dest;
                result.data <= {{(32 - FLAG_W){1'b0}}, vec_next};
            end
        end
    end

endmodule : fmc_cmp_probe
`default_nettype wire

// [design/fmc_top.sv]
// float multiplier with sticky status word, plus the less-than flag probe
// assumes issue logic and register file on mclk; wishbone classic slave for software
`timescale 1ns/1ps
`default_nettype none
module fmc_top #(
    parameter int LATENCY = fmc_pkg::MUL_LATENCY
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire fmc_pkg::fmc_issue_t cmp_issue,
    input wire fmc_pkg::fmc_issue_t mul_issue,
    output fmc_pkg::fmc_wb_t cmp_result,
    output fmc_pkg::fmc_wb_t mul_result,
    output logic [31:0] status_word,
    output logic irq
);
    import fmc_pkg::*;

    if (LATENCY < 1) begin : g_bad_latency
        $error("fmc_top: LATENCY must be at least 1");
    end

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic [31:0] status_word_reg;
    logic [IRQ_W-1:0] irq_status_reg;
    logic [IRQ_W-1:0] irq_mask_reg;
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic bus_write;
    logic bus_req;
    logic mul_take;
    logic mul_refused;
    logic probe_flagged;
    fmc_rmode_t rmode;

    logic [7:0] ea;
    logic [7:0] eb;
    logic a_zero;
    logic b_zero;
    logic a_inf;
    logic b_inf;
    logic a_nan;
    logic b_nan;
    logic sign;
    logic [47:0] mprod;
    logic hi;
    logic [23:0] mant;
    logic grd;
    logic sticky;
    logic inc;
    logic [24:0] mant_r;
    logic [9:0] exp_s;
    logic [9:0] exp_r;
    logic [31:0] prod_next;
    logic [FLAG_W-1:0] flags_next;

    logic pipe_valid [LATENCY];
    logic [DEST_W-1:0] pipe_dest [LATENCY];
    logic [31:0] pipe_prod [LATENCY];
    logic [FLAG_W-1:0] pipe_flags [LATENCY];

    // ------------------------------------------------------------------
    // compare flag probe
    // ------------------------------------------------------------------
    fmc_cmp_probe u_probe (
        .mclk(mclk),
        .rst(rst),
        .issue(cmp_issue),
        .result(cmp_result),
        .flagged(probe_flagged)
    );

    // ------------------------------------------------------------------
    // multiplier: issue acceptance
    // ------------------------------------------------------------------
    // a squashed multiply never enters the pipe, so it can raise no flag
    assign mul_take = mul_issue.valid && mul_issue.guard && (mul_issue.opcode == OPC_FMUL)
        && ((mul_issue.slot == MUL_SLOT_A) || (mul_issue.slot == MUL_SLOT_B));
    assign mul_refused = mul_issue.valid && mul_issue.guard && (mul_issue.opcode == OPC_FMUL)
        && !mul_take;
    assign rmode = fmc_rmode_t'(status_word_reg[RMODE_LSB +: 2]);

    // ------------------------------------------------------------------
    // multiplier: operand classes
    // ------------------------------------------------------------------
    // exponent zero covers both true zero and denormal, which flush to zero
    always_comb begin
        ea = mul_issue.first_operand[30:23];
        eb = mul_issue.second_operand[30:23];
        a_zero = (ea == 8'h00);
        b_zero = (eb == 8'h00);
        a_inf = (ea == EXP_ALL_ONES) && (mul_issue.first_operand[22:0] == 23'h000000);
        b_inf = (eb == EXP_ALL_ONES) && (mul_issue.second_operand[22:0] == 23'h000000);
        a_nan = (ea == EXP_ALL_ONES) && !a_inf;
        b_nan = (eb == EXP_ALL_ONES) && !b_inf;
        sign = mul_issue.first_operand[31] ^ mul_issue.second_operand[31];
    end

    // ------------------------------------------------------------------
    // multiplier: mantissa product, normalise, round
    // ------------------------------------------------------------------
    always_comb begin
        mprod = {1'b1, mul_issue.first_operand[22:0]} * {1'b1, mul_issue.second_operand[22:0]};
        hi = mprod[47];
        mant = hi ? mprod[47:24] : mprod[46:23];
        grd = hi ? mprod[23] : mprod[22];
        sticky = hi ? (mprod[22:0] != 23'h000000) : (mprod[21:0] != 22'h000000);
        exp_s = {2'b00, ea} + {2'b00, eb} - EXP_BIAS + {9'h000, hi};
        unique case (rmode)
            RM_NEAREST: inc = grd && (sticky || mant[0]);
            RM_TO_ZERO: inc = 1'b0;
            RM_TO_POS: inc = !sign && (grd || sticky);
            RM_TO_NEG: inc = sign && (grd || sticky);
        endcase
        mant_r = {1'b0, mant} + {24'h000000, inc};
        exp_r = exp_s + {9'h000, mant_r[24]};
    end

    // ------------------------------------------------------------------
    // multiplier: special cases and result selection
    // ------------------------------------------------------------------
    always_comb begin
        prod_next = '0;
        flags_next = '0;
        flags_next[BIT_INPUT_FLUSHED] = (a_zero && mul_issue.first_operand[22:0] != 23'h000000)
            || (b_zero && mul_issue.second_operand[22:0] != 23'h000000);
        if (a_nan || b_nan) begin
            prod_next = QNAN_PATTERN;
            // only a signalling NaN (quiet bit clear) is a bad operand
            flags_next[BIT_BAD_OPERAND] = (a_nan && !mul_issue.first_operand[22])
                || (b_nan && !mul_issue.second_operand[22]);
        end else if ((a_inf && b_zero) || (b_inf && a_zero)) begin
            prod_next = QNAN_PATTERN;
            flags_next[BIT_BAD_OPERAND] = 1'b1;
        end else if (a_inf || b_inf) begin
            prod_next = {sign, INF_MAG};
        end else if (a_zero || b_zero) begin
            prod_next = {sign, 31'h00000000};
        end else if (exp_s[9] || exp_s == 10'h000) begin
            // the flush is judged before rounding; a product that would round up
            // into the smallest normal is still flushed
            prod_next = 32'h00000000;
            flags_next[BIT_TOO_SMALL] = 1'b1;
            flags_next[BIT_PRECISION_LOSS] = 1'b1;
            flags_next[BIT_OUTPUT_FLUSHED] = ($signed(exp_s) >= $signed(DENORM_FLOOR) + 10'sd1)
                ;
        end else if (exp_r >= EXP_LIMIT) begin
            flags_next[BIT_TOO_LARGE] = 1'b1;
            flags_next[BIT_PRECISION_LOSS] = 1'b1;
            unique case (rmode)
                RM_NEAREST: prod_next = {sign, INF_MAG};
                RM_TO_ZERO: prod_next = {sign, MAX_FINITE_MAG};
                RM_TO_POS: prod_next = sign ? {1'b1, MAX_FINITE_MAG} : {1'b0, INF_MAG};
                RM_TO_NEG: prod_next = sign ? {1'b1, INF_MAG} : {1'b0, MAX_FINITE_MAG};
            endcase
        end else begin
            prod_next = {sign, exp_r[7:0], mant_r[24] ? mant_r[23:1] : mant_r[22:0]};
            flags_next[BIT_PRECISION_LOSS] = grd || sticky;
        end
    end

    // ------------------------------------------------------------------
    // multiplier: pipeline
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            pipe_valid[0] <= 1'b0;
            pipe_dest[0] <= '0;
            pipe_prod[0] <= '0;
            pipe_flags[0] <= '0;
        end else begin
            pipe_valid[0] <= mul_take;
            pipe_dest[0] <= mul_issue.dest;
            pipe_prod[0] <= prod_next;
            pipe_flags[0] <= flags_next;
        end
    end

    for (genvar i = 1; i < LATENCY; i++) begin : g_pipe
        always_ff @(posedge mclk) begin
            if (rst) begin
                pipe_valid[i] <= 1'b0;
                pipe_dest[i] <= '0;
                pipe_prod[i] <= '0;
                pipe_flags[i] <= '0;
            end else begin
                pipe_valid[i] <= pipe_valid[i-1];
                pipe_dest[i] <= pipe_dest[i-1];
                pipe_prod[i] <= pipe_prod[i-1];
                pipe_flags[i] <= pipe_flags[i-1];
            end
        end
    end

    assign mul_result.valid = pipe_valid[LATENCY-1];
    assign mul_result.dest = pipe_dest[LATENCY-1];
    assign mul_result.data = pipe_prod[LATENCY-1];

    // ------------------------------------------------------------------
    // wishbone slave
    // ------------------------------------------------------------------
    // ack comes one cycle after the strobe and drops the cycle after
    assign bus_req = wb_cyc_i && wb_stb_i && !ack_reg;
    assign bus_write = bus_req && wb_we_i;

    always_ff @(posedge mclk) begin
        if (rst) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= bus_req;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata_reg <= '0;
        end else if (bus_req && !wb_we_i) begin
            unique case (wb_adr_i)
                ADDR_STATUS_WORD: rdata_reg <= status_word_reg;
                ADDR_IRQ_STATUS: rdata_reg <= {{(32 - IRQ_W){1'b0}}, irq_status_reg};
                ADDR_IRQ_MASK: rdata_reg <= {{(32 - IRQ_W){1'b0}}, irq_mask_reg};
                default: rdata_reg <= 32'h00000000;
            endcase
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;

    // ------------------------------------------------------------------
    // status word
    // ------------------------------------------------------------------
    // the write lands in the strobe cycle; a flag raised in the same cycle
    // is ORed on top so a software clear never hides a fresh exception
    always_ff @(posedge mclk) begin
        if (rst) begin
            status_word_reg <= STATUS_WORD_RESET;
        end else begin
            status_word_reg <= (status_word_reg & ~{{(32 - FLAG_W){1'b0}}, FLAG_IMPL_MASK})
                | {{(32 - FLAG_W){1'b0}}, status_word_reg[FLAG_W-1:0] & FLAG_IMPL_MASK}
                | (pipe_valid[LATENCY-1]
                   ? {{(32 - FLAG_W){1'b0}}, pipe_flags[LATENCY-1]} : 32'h00000000)
                ;
            if (bus_write && wb_adr_i == ADDR_STATUS_WORD) begin
                for (int b = 0; b < 2; b++) begin
                    if (wb_sel_i[b]) begin
                        status_word_reg[b*8 +: 8] <= wb_dat_i[b*8 +: 8]
                            | ((pipe_valid[LATENCY-1] && b == 0)
                               ? {1'b0, pipe_flags[LATENCY-1]} : 8'h00);
                    end
                end
            end
        end
    end

    // bits outside the flag field and rounding mode read zero on status_word; a bus read returns them unmasked
    assign status_word = status_word_reg & {22'h000000, 2'h3, 1'b0, FLAG_IMPL_MASK};

    // ------------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_mask_reg <= '0;
        end else if (bus_write && wb_adr_i == ADDR_IRQ_MASK && wb_sel_i[0]) begin
            irq_mask_reg <= wb_dat_i[IRQ_W-1:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_status_reg <= '0;
        end else begin
            // set wins over a write-one clear in the same cycle
            irq_status_reg <= (irq_status_reg
                & ~((bus_write && wb_adr_i == ADDR_IRQ_STATUS && wb_sel_i[0])
                    ? wb_dat_i[IRQ_W-1:0] : {IRQ_W{1'b0}}))
                | {mul_refused, probe_flagged,
                   pipe_valid[LATENCY-1] && (pipe_flags[LATENCY-1] != '0)};
        end
    end

    assign irq = (irq_status_reg & irq_mask_reg) != '0;

endmodule : fmc_top
`default_nettype wire

// [dv/fmc_asserts.sv]
// checker of the float multiply / compare-probe unit, bound to fmc_top
// assumes only the top's ports; issue and result carriers come from fmc_pkg
`timescale 1ns/1ps
`default_nettype none
module fmc_asserts
    import fmc_pkg::*;
#(
    parameter int LATENCY = 3
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire fmc_pkg::fmc_issue_t cmp_issue,
    input wire fmc_pkg::fmc_issue_t mul_issue,
    input wire fmc_pkg::fmc_wb_t cmp_result,
    input wire fmc_pkg::fmc_wb_t mul_result,
    input wire logic [31:0] status_word
);
    function automatic logic qn(input logic [31:0] x);
        return x[30:23] == 8'hFF && x[22];
    endfunction : qn
    function automatic logic dn(input logic [31:0] x);
        return x[30:23] == 8'h00 && x[22:0] != 23'h0;
    endfunction : dn
    logic ct, mt, wr;
    assign ct = cmp_issue.valid && cmp_issue.guard && cmp_issue.opcode == OPC_PROBE_LT;
    assign mt = mul_issue.valid && mul_issue.guard && mul_issue.opcode == OPC_FMUL
        && mul_issue.slot[1];
    // any bus write may touch the status word, so quiet checks exclude it
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // ----------
    // properties
    // ----------
    probe_latency_a: assert property (ct |=> cmp_result.valid)
        else $error("probe result missing");
    probe_guard_a: assert property (cmp_issue.valid && !cmp_issue.guard
        |=> !cmp_result.valid) else $error("guarded-off probe wrote");
    probe_spare_a: assert property (cmp_result.valid
        |-> (cmp_result.data & ~32'h7E) == 32'h0) else $error("probe spare bits set");
    probe_nan_a: assert property (ct
        && (qn(cmp_issue.first_operand) || qn(cmp_issue.second_operand))
        && !dn(cmp_issue.first_operand) && !dn(cmp_issue.second_operand)
        |=> cmp_result.data == 32'h10) else $error("nan probe vector wrong");
    probe_flush_a: assert property (ct
        && (dn(cmp_issue.first_operand) || dn(cmp_issue.second_operand))
        |=> cmp_result.data[BIT_INPUT_FLUSHED]) else $error("input flush bit missing");
    mul_latency_a: assert property (mt |-> ##LATENCY mul_result.valid)
        else $error("product late or missing");
    mul_guard_a: assert property (mul_issue.valid && !mul_issue.guard
        |-> ##LATENCY !mul_result.valid) else $error("guarded-off multiply wrote");
    mul_invalid_a: assert property (mt && mul_issue.first_operand[30:0] == INF_MAG
        && mul_issue.second_operand[30:0] == 31'h0
        |-> ##LATENCY mul_result.data == QNAN_PATTERN ##1 status_word[BIT_BAD_OPERAND])
        else $error("inf times zero wrong");
    flags_sticky_a: assert property (!wr
        |=> (status_word & $past(status_word)) == $past(status_word))
        else $error("status flag dropped");
    status_quiet_a: assert property (!wr && !mul_result.valid |=> $stable(status_word))
        else $error("status changed off a product edge");
    probe_seen_c: cover property (ct);
    mul_seen_c: cover property (mt);
    status_write_c: cover property (wr);
endmodule : fmc_asserts

bind fmc_top fmc_asserts #(.LATENCY(LATENCY)) i_fmc_asserts (
    .mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .cmp_issue(cmp_issue), .mul_issue(mul_issue), .cmp_result(cmp_result),
    .mul_result(mul_result), .status_word(status_word)
);
`default_nettype wire

// [dv/fmc_issue_model.sv]
// issue logic and register file model facing fmc_top
// assumes mclk only; the bench calls issue() and idle() between edges
`timescale 1ns/1ps
`default_nettype none
module fmc_issue_model (
    input wire logic mclk,
    output var fmc_pkg::fmc_issue_t cmp_issue,
    output var fmc_pkg::fmc_issue_t mul_issue,
    input wire fmc_pkg::fmc_wb_t cmp_result,
    input wire fmc_pkg::fmc_wb_t mul_result
);
    import fmc_pkg::*;
    logic [31:0] regs [128];
    initial begin
        cmp_issue = '0;
        mul_issue = '0;
        regs = '{default: 32'hA5A5A5A5};
    end
    // ----------
    // register file and issue
    // ----------
    always @(posedge mclk) begin
        if (cmp_result.valid === 1'b1) regs[cmp_result.dest] <= cmp_result.data;
        if (mul_result.valid === 1'b1) regs[mul_result.dest] <= mul_result.data;
    end
    task automatic issue(input logic m, input logic g, input logic [7:0] op,
            input logic [1:0] sl, input logic [31:0] a, input logic [31:0] b,
            input logic [6:0] d);
        @(posedge mclk);
        if (m) begin
            mul_issue <= '{1'b1, g, op, sl, a, b, d};
            cmp_issue.valid <= 1'b0;
        end else begin
            cmp_issue <= '{1'b1, g, op, sl, a, b, d};
            mul_issue.valid <= 1'b0;
        end
    endtask : issue
    // idle operands flip so a unit that ignores valid sees junk, not stale data
    task automatic idle();
        @(posedge mclk);
        cmp_issue <= '{first_operand: ~cmp_issue.first_operand,
            second_operand: ~cmp_issue.second_operand, default: '0};
        mul_issue <= '{first_operand: ~mul_issue.first_operand,
            second_operand: ~mul_issue.second_operand, default: '0};
    endtask : idle
endmodule : fmc_issue_model
`default_nettype wire

// [dv/tb_fmc_top.sv]
// testbench of the float multiply / compare-probe unit
// assumes fmc_top, fmc_issue_model and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_fmc_top;
    import fmc_pkg::*;
    localparam logic [31:0] PA [6] = '{32'h40400000, 32'h40400000, 32'h3F800000,
        32'h7F800000, 32'h00400000, 32'h3F800000};
    localparam logic [31:0] PB [6] = '{32'h00000000, 32'hFFFFFFFF, 32'h00400000,
        32'hFF800000, 32'h7FC00000, 32'h40400000};
    localparam logic [31:0] PX [6] = '{32'h0, 32'h10, 32'h20, 32'h0, 32'h30, 32'hA5A5A5A5};
    localparam logic [31:0] MA [9] = '{32'hC0400000, 32'h40400000, 32'h40400000, 32'h3F000000,
        32'h7F800000, 32'h40400000, 32'h00800000, 32'h7F800000, 32'h7F7FFFFF};
    localparam logic [31:0] MB [9] = '{32'h3F800000, 32'hC0400000, 32'h00800000, 32'h00800000,
        32'h00000000, 32'h00400000, 32'h00800000, 32'hFF800000, 32'h7F7FFFFF};
    localparam logic [31:0] MP [9] = '{32'hC0400000, 32'hC1100000, 32'h01400000, 32'h0,
        32'hFFFFFFFF, 32'h0, 32'h0, 32'hFF800000, 32'h7F800000};
    localparam logic [31:0] MF [9] = '{32'h0, 32'h0, 32'h0, 32'h46, 32'h10, 32'h20, 32'h06,
        32'h0, 32'h0A};
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [3:0] sel = 4'h0;
    logic [31:0] rdat, wb_q, status_word;
    logic ack, irq;
    fmc_issue_t cmp_issue, mul_issue;
    fmc_wb_t cmp_result, mul_result;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;

    fmc_top #(.LATENCY(MUL_LATENCY)) i_fmc_top (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
        .wb_dat_o(rdat), .wb_ack_o(ack), .cmp_issue(cmp_issue), .mul_issue(mul_issue),
        .cmp_result(cmp_result), .mul_result(mul_result), .status_word(status_word), .irq(irq));
    fmc_issue_model i_fmc_issue_model (.mclk(mclk), .cmp_issue(cmp_issue),
        .mul_issue(mul_issue), .cmp_result(cmp_result), .mul_result(mul_result));

    initial forever #2.5 mclk = ~mclk;
    // ----------
    // shared tasks
    // ----------
    task summarize;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            summarize();
        end
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    function logic [31:0] rg(input int i);
        return i_fmc_issue_model.regs[i];
    endfunction : rg
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        do @(posedge mclk); while (ack !== 1'b1);
        wb_q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    // latency is fixed by the unit, so a fixed wait covers both pipes
    task op(input logic m, input logic g, input logic [31:0] a, b,
            input logic [6:0] d, input logic [1:0] sl);
        i_fmc_issue_model.issue(m, g, m ? OPC_FMUL : OPC_PROBE_LT, sl, a, b, d);
        i_fmc_issue_model.idle();
        repeat (MUL_LATENCY + 1) @(posedge mclk);
    endtask : op
    task t_probe;
        wb(1'b1, ADDR_STATUS_WORD, 32'h00000102, 4'h3);
        for (int i = 0; i < 6; i++) begin
            i_fmc_issue_model.issue(1'b0, i != 5, OPC_PROBE_LT, 2'h3, PA[i], PB[i], 7'(20 + i));
        end
        op(1'b0, 1'b0, 32'h0, 32'h0, 7'h7F, 2'h3);
        for (int i = 0; i < 6; i++) begin
            chk(rg(20 + i), PX[i]);
        end
        chk(status_word, 32'h00000102);
    endtask : t_probe
    task t_mul;
        for (int i = 0; i < 9; i++) begin
            wb(1'b1, ADDR_STATUS_WORD, 32'h0, 4'h3);
            op(1'b1, 1'b1, MA[i], MB[i], 7'(40 + i), {1'b1, i[0]});
            chk(rg(40 + i), MP[i]);
            chk(status_word & 32'h7E, MF[i]);
        end
        wb(1'b0, ADDR_STATUS_WORD, 32'h0, 4'hF);
        chk(wb_q & 32'h7E, 32'h0A);
    endtask : t_mul
    task t_round;
        for (int m = 0; m < 4; m++) begin
            wb(1'b1, ADDR_STATUS_WORD, 32'(m) << RMODE_LSB, 4'h3);
            op(1'b1, 1'b1, 32'h3F800001, 32'h3F800001, 7'h50, 2'h2);
            chk(rg(80), m == 2 ? 32'h3F800003 : 32'h3F800002);
            chk(status_word & 32'h7E, 32'h02);
        end
    endtask : t_round
    task t_sticky;
        wb(1'b1, ADDR_STATUS_WORD, 32'h0, 4'h3);
        wb(1'b1, ADDR_IRQ_MASK, 32'h1, 4'h1);
        i_fmc_issue_model.issue(1'b1, 1'b1, OPC_FMUL, 2'h2, 32'h7F7FFFFF, 32'h7F7FFFFF, 7'h60);
        op(1'b1, 1'b1, 32'h7F800000, 32'h0, 7'h61, 2'h3);
        chk(status_word & 32'h7E, 32'h1A);
        chk({31'h0, irq}, 32'h1);
        op(1'b1, 1'b0, 32'h3F000000, 32'h00800000, 7'h62, 2'h2);
        op(1'b0, 1'b1, 32'h7FC00000, 32'h3F800000, 7'h63, 2'h2);
        chk(rg(98), 32'hA5A5A5A5);
        chk(rg(99), 32'h10);
        wb(1'b1, ADDR_IRQ_STATUS, 32'h1, 4'h1);
        chk({31'h0, irq}, 32'h0);
        chk(status_word & 32'h7E, 32'h1A);
        wb(1'b1, ADDR_STATUS_WORD, 32'h0, 4'h3);
        chk(status_word, 32'h0);
        op(1'b1, 1'b1, 32'h3F800000, 32'h3F800000, 7'h64, 2'h0);
        chk(rg(100), 32'hA5A5A5A5);
        wb(1'b0, ADDR_IRQ_STATUS, 32'h0, 4'hF);
        chk(wb_q & 32'h4, 32'h4);
        wb(1'b0, 8'h0C, 32'h0, 4'hF);
        chk(wb_q, 32'h0);
    endtask : t_sticky
    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        t_probe();
        t_mul();
        t_round();
        t_sticky();
        summarize();
    end
endmodule : tb_fmc_top
`default_nettype wire
